// ===== design/aclc_pkg.sv
/*
  Constants and helpers for the codec side of the five-wire audio link.
  Assumes a 100 MHz system clock and an APB master with 32-bit data.
*/
package aclc_pkg;

  localparam int CLK_HZ  = 100_000_000;
  localparam int MCLK_HZ = 24_576_000;
  localparam int BCLK_HZ = MCLK_HZ / 2;
  // System cycles per bit-clock half period
  localparam logic [7:0] BCLK_HALF_CYC = 8'(CLK_HZ / (2 * BCLK_HZ));

  localparam int COLD_NS = 1000;
  localparam int WARM_NS = 1000;
  localparam logic [7:0] COLD_CYC = 8'((COLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam logic [7:0] WARM_CYC = 8'((WARM_NS * (CLK_HZ / 1_000_000) + 999) / 1000);

  localparam logic [4:0] TAG_LAST  = 5'h0F;
  localparam logic [4:0] SLOT_LAST = 5'h13;
  localparam logic [3:0] SLOT_MAX  = 4'hC;
  localparam int TAG_VALID = 15;
  localparam int TAG_CMD   = 14;
  localparam int TAG_DATA  = 13;
  localparam int TAG_LEFT  = 12;
  localparam int TAG_RIGHT = 11;

  localparam int CMD_RW    = 19;
  localparam int IDX_HI    = 18;
  localparam int IDX_LO    = 12;
  localparam int DATA_HI   = 19;
  localparam int DATA_LO   = 4;

  localparam logic [6:0] IDX_RESET  = 7'h00;
  localparam logic [6:0] IDX_PWR    = 7'h26;
  localparam int         PWR_HALT   = 12;
  localparam logic [15:0] CREG_DEFAULT = 16'h0000;

  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CMD    = 8'h08;
  localparam logic [7:0] OFF_PCM_L  = 8'h0C;
  localparam logic [7:0] OFF_PCM_R  = 8'h10;
  localparam logic [7:0] OFF_FRAMES = 8'h14;
  localparam int CTRL_READY_EN = 0;
  localparam logic CTRL_READY_EN_RST = 1'b1;

  function automatic logic apb_mapped(input logic [7:0] a);
    return a == OFF_CTRL || a == OFF_STATUS || a == OFF_CMD ||
           a == OFF_PCM_L || a == OFF_PCM_R || a == OFF_FRAMES;
  endfunction

endpackage

// ===== design/aclc_bclk_gen.sv
/*
  Bit-clock divider: toggles the link clock every half period while running
  and flags each rise and fall as one-cycle enables.
  Assumes the run level comes from logic on the same clock.
*/
`timescale 1ns/1ps
module aclc_bclk_gen (
  input  wire logic clock,    // System clock
  input  wire logic rstn,     // Async reset, active low
  input  wire logic run,      // Link clock allowed to run
  output logic      bit_clk,  // Link bit clock
  output logic      rise_en,  // Bit clock rises at this edge
  output logic      fall_en   // Bit clock falls at this edge
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       bclk;
  } aclc_gen_t;

  aclc_gen_t st;
  aclc_gen_t next_st;
  logic      wrap;

  assign wrap    = run && st.cnt == aclc_pkg::BCLK_HALF_CYC - 8'h01;
  assign rise_en = wrap && !st.bclk;
  assign fall_en = wrap && st.bclk;
  assign bit_clk = st.bclk;

  always_comb begin
    next_st = st;
    if (!run) begin
      next_st.cnt  = '0;
      next_st.bclk = 1'b0;
    end else if (wrap) begin
      next_st.cnt  = '0;
      next_st.bclk = ~st.bclk;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // aclc_bclk_gen

// ===== design/aclc_codec.sv
/*
  Codec end of the audio link: makes the bit clock, decodes outgoing frames
  (tag, command, write data, playback samples), keeps the control register
  file and returns read data in the next incoming frame. APB slave for status.
  Assumes the controller makes sync from the bit clock; link pins are async.
*/
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module aclc_codec (
  input  wire logic        clock,        // System clock, 100 MHz
  input  wire logic        rstn,         // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB write
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error on unmapped address
  input  wire logic        reset_pin_n,  // Link reset pin, active low
  input  wire logic        sync,         // Frame sync from controller
  input  wire logic        sdata_out,    // Serial stream into the codec
  output logic             bit_clk,      // Link bit clock out
  output logic             sdata_in,     // Serial stream to the controller
  output logic             codec_ready,  // Ready flag as sent in the tag
  output logic      [19:0] pcm_left,     // Last left playback sample
  output logic      [19:0] pcm_right,    // Last right playback sample
  output logic             pcm_valid     // Pulse: new left or right sample
);

  typedef struct packed {
    logic             rst_m;
    logic             rst_s;
    logic             syn_m;
    logic             syn_s;
    logic             dat_m;
    logic             dat_s;
    logic [7:0]       cold_cnt;
    logic             cold_active;
    logic [7:0]       warm_cnt;
    logic             run;
    logic             sync_prev;
    logic             in_frame;
    logic [3:0]       slot;
    logic [4:0]       pos;
    logic [19:0]      rxsh;
    logic [15:0]      tag;
    logic             cmd_rw;
    logic [6:0]       cmd_idx;
    logic             rd_pend;
    logic [6:0]       rd_idx;
    logic [55:0]      txsh;
    logic             sdata_in;
    logic             ready;
    logic [19:0]      pcm_l;
    logic [19:0]      pcm_r;
    logic [19:0]      pcm_hold;
    logic             pcm_valid;
    logic [63:0][15:0] creg;
    logic             ready_en;
    logic [15:0]      frames;
    logic [31:0]      last_cmd;
    logic [31:0]      prdata;
  } aclc_st_t;

  localparam aclc_st_t ST_INIT = '{
    cold_active: 1'b1,
    ready_en:    aclc_pkg::CTRL_READY_EN_RST,
    creg:        {64{aclc_pkg::CREG_DEFAULT}},
    default:     '0
  };

  aclc_st_t st;
  aclc_st_t next_st;
  logic     rise_en;
  logic     fall_en;
  logic     bclk;

  aclc_bclk_gen u_bclk (
    .clock   (clock),
    .rstn    (rstn),
    .run     (st.run),
    .bit_clk (bclk),
    .rise_en (rise_en),
    .fall_en (fall_en)
  );

  // Odd indices are reserved and read as zero
  function automatic logic [15:0] creg_read(input logic [63:0][15:0] r,
                                            input logic [6:0] idx);
    return idx[0] ? 16'h0000 : r[idx[6:1]];
  endfunction

  function automatic logic [31:0] apb_read(input aclc_st_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      aclc_pkg::OFF_CTRL:   v[aclc_pkg::CTRL_READY_EN] = s.ready_en;
      aclc_pkg::OFF_STATUS: v = {28'h0, s.rd_pend, s.in_frame, s.run, s.ready};
      aclc_pkg::OFF_CMD:    v = s.last_cmd;
      aclc_pkg::OFF_PCM_L:  v = {12'h000, s.pcm_l};
      aclc_pkg::OFF_PCM_R:  v = {12'h000, s.pcm_r};
      aclc_pkg::OFF_FRAMES: v = {16'h0000, s.frames};
      default:              v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign prdata      = st.prdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && !aclc_pkg::apb_mapped(paddr);
  assign bit_clk     = bclk;
  assign sdata_in    = st.sdata_in;
  assign codec_ready = st.ready;
  assign pcm_left    = st.pcm_l;
  assign pcm_right   = st.pcm_r;
  assign pcm_valid   = st.pcm_valid;

  always_comb begin
    logic [19:0] w;
    logic [15:0] rdat;
    logic        last;
    logic        frame_ok;
    logic        rd_now;
    w        = '0;
    rdat     = '0;
    last     = 1'b0;
    frame_ok = 1'b0;
    rd_now   = 1'b0;
    next_st  = st;
    next_st.pcm_valid = 1'b0;

    // Two-stage synchronisers for the link pins
    next_st.rst_m = reset_pin_n;
    next_st.rst_s = st.rst_m;
    next_st.syn_m = sync;
    next_st.syn_s = st.syn_m;
    next_st.dat_m = sdata_out;
    next_st.dat_s = st.dat_m;

    // Warm restart: sync held high while the clock is stopped
    if (!st.run && !st.cold_active && st.rst_s) begin
      if (st.syn_s) begin
        if (st.warm_cnt != aclc_pkg::WARM_CYC) begin
          next_st.warm_cnt = st.warm_cnt + 8'h01;
        end
      end else begin
        if (st.warm_cnt == aclc_pkg::WARM_CYC) begin
          next_st.run       = 1'b1;
          next_st.sync_prev = 1'b0;
        end
        next_st.warm_cnt = '0;
      end
    end else begin
      next_st.warm_cnt = '0;
    end

    // Receive: sample on each bit-clock fall
    if (st.run && fall_en) begin
      next_st.sync_prev = st.syn_s;
      if (st.syn_s && !st.sync_prev) begin
        // Frame start seen; first data bit comes after the next rise
        next_st.in_frame = 1'b1;
        next_st.slot     = '0;
        next_st.pos      = '0;
        next_st.frames   = st.frames + 16'h0001;
        rdat = creg_read(st.creg, st.rd_idx);
        // Answer last frame's read, zero-filled otherwise
        next_st.txsh = {st.ready, st.rd_pend, st.rd_pend, 13'h0000,
                        1'b0, st.rd_pend ? st.rd_idx : 7'h00, 12'h000,
                        st.rd_pend ? rdat : 16'h0000, 4'h0};
        next_st.rd_pend = 1'b0;
      end else if (st.in_frame) begin
        w = {st.rxsh[18:0], st.dat_s};
        next_st.rxsh = w;
        last = (st.slot == 4'h0) ? (st.pos == aclc_pkg::TAG_LAST)
                                 : (st.pos == aclc_pkg::SLOT_LAST);
        frame_ok = st.tag[aclc_pkg::TAG_VALID] && st.tag[1:0] == 2'b00;
        if (!last) begin
          next_st.pos = st.pos + 5'h01;
        end else begin
          next_st.pos  = '0;
          next_st.slot = st.slot + 4'h1;
          if (st.slot == aclc_pkg::SLOT_MAX) begin
            next_st.in_frame = 1'b0;
          end
          case (st.slot)
            4'h0: next_st.tag = w[15:0];
            4'h1: begin
              next_st.cmd_rw  = w[aclc_pkg::CMD_RW];
              next_st.cmd_idx = w[aclc_pkg::IDX_HI:aclc_pkg::IDX_LO];
            end
            4'h2: begin
              if (frame_ok && st.tag[aclc_pkg::TAG_CMD]) begin
                next_st.last_cmd = {st.cmd_rw, 4'h0, st.cmd_idx, 4'h0,
                                    w[aclc_pkg::DATA_HI:aclc_pkg::DATA_LO]};
                if (st.cmd_rw) begin
                  rd_now = 1'b1;
                end else if (st.tag[aclc_pkg::TAG_DATA]) begin
                  if (st.cmd_idx == aclc_pkg::IDX_RESET) begin
                    next_st.creg = {64{aclc_pkg::CREG_DEFAULT}};
                  end else if (!st.cmd_idx[0]) begin
                    next_st.creg[st.cmd_idx[6:1]] =
                      w[aclc_pkg::DATA_HI:aclc_pkg::DATA_LO];
                    if (st.cmd_idx == aclc_pkg::IDX_PWR && w[aclc_pkg::PWR_HALT + 4]) begin
                      next_st.run = 1'b0;
                    end
                  end
                end
              end
              if (rd_now) begin
                next_st.rd_pend = 1'b1;
                next_st.rd_idx  = st.cmd_idx;
              end
            end
            // Left is held so that both samples update with the pulse
            4'h3: next_st.pcm_hold = w;
            4'h4: begin
              if (frame_ok && st.tag[aclc_pkg::TAG_LEFT]) begin
                next_st.pcm_l = st.pcm_hold;
              end
              if (frame_ok && st.tag[aclc_pkg::TAG_RIGHT]) begin
                next_st.pcm_r = w;
              end
              next_st.pcm_valid = frame_ok &&
                (st.tag[aclc_pkg::TAG_LEFT] || st.tag[aclc_pkg::TAG_RIGHT]);
            end
            default: ;
          endcase
        end
      end
    end

    // Transmit: shift out on each bit-clock rise
    if (st.run && rise_en) begin
      next_st.sdata_in = st.txsh[55];
      next_st.txsh     = {st.txsh[54:0], 1'b0};
    end
    if (!st.run) begin
      next_st.sdata_in = 1'b0;
      next_st.in_frame = 1'b0;
      next_st.txsh     = '0;
    end

    next_st.ready = st.run && st.ready_en && !st.cold_active;

    // APB: read data captured in setup, write taken in access
    if (psel && !penable) begin
      next_st.prdata = apb_read(st, paddr);
    end
    if (psel && penable && pwrite && paddr == aclc_pkg::OFF_CTRL) begin
      next_st.ready_en = pwdata[aclc_pkg::CTRL_READY_EN];
    end

    // Cold reset from the link pin dominates everything on the link side
    if (!st.rst_s) begin
      if (st.cold_cnt != aclc_pkg::COLD_CYC) begin
        next_st.cold_cnt = st.cold_cnt + 8'h01;
      end else begin
        next_st.cold_active = 1'b1;
        next_st.run         = 1'b0;
        next_st.creg        = {64{aclc_pkg::CREG_DEFAULT}};
        next_st.rd_pend     = 1'b0;
        next_st.rd_idx      = '0;
        next_st.in_frame    = 1'b0;
        next_st.sync_prev   = 1'b0;
        next_st.tag         = '0;
        next_st.txsh        = '0;
        next_st.sdata_in    = 1'b0;
        next_st.pcm_l       = '0;
        next_st.pcm_r       = '0;
        next_st.pcm_hold    = '0;
        next_st.last_cmd    = '0;
        next_st.ready       = 1'b0;
      end
    end else begin
      next_st.cold_cnt = '0;
      if (st.cold_active) begin
        next_st.cold_active = 1'b0;
        next_st.run         = 1'b1;
        next_st.sync_prev   = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st <= ST_INIT;
    end else begin
      st <= next_st;
    end
  end

endmodule // aclc_codec

// ===== tb/aclc_codec_props.sv
/*
  Port checker for the codec: APB answers, bit clock shape, playback pulses, cold reset.
  Assumes it is bound to aclc_codec and sees its ports only.
*/
`timescale 1ns/1ps
module aclc_codec_props (
  input wire logic        clock,        // Clock
  input wire logic        rstn,         // Reset
  input wire logic        psel,         // APB
  input wire logic        penable,      // APB
  input wire logic        pwrite,       // APB
  input wire logic [7:0]  paddr,        // APB
  input wire logic [31:0] pwdata,       // APB
  input wire logic [31:0] prdata,       // APB
  input wire logic        pready,       // APB
  input wire logic        pslverr,      // APB
  input wire logic        reset_pin_n,  // Link
  input wire logic        sync,         // Link
  input wire logic        sdata_out,    // Link
  input wire logic        bit_clk,      // Link
  input wire logic        sdata_in,     // Link
  input wire logic        codec_ready,  // Ready
  input wire logic [19:0] pcm_left,     // PCM
  input wire logic [19:0] pcm_right,    // PCM
  input wire logic        pcm_valid     // PCM
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic [7:0] low_cnt;
  // Cycles the link reset pin has been low
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) low_cnt <= 8'h00;
    else if (reset_pin_n) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_low4;
    !bit_clk [*4];
  endsequence
  AST_PREADY: assert property (s_acc |-> pready) else $error("pready low in access");
  AST_UNMAP: assert property (psel && penable && (paddr > 8'h14 || paddr[1:0] != 2'h0)
    |-> pslverr) else $error("no error on unmapped address");
  AST_MAP: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped address");
  AST_PRD_HOLD: assert property (s_acc ##1 !psel |-> $stable(prdata))
    else $error("read data moved after access");
  AST_BCLK_LOW: assert property ($fell(bit_clk) |-> s_low4)
    else $error("bit clock low phase short");
  AST_SDIN_EDGE: assert property ($changed(sdata_in) && codec_ready && $past(codec_ready)
    && reset_pin_n |-> $rose(bit_clk)) else $error("sdata_in moved off a rise");
  AST_PCM_PULSE: assert property (pcm_valid |=> !pcm_valid [*8])
    else $error("pcm_valid not a single pulse");
  AST_PCM_HOLD: assert property (($changed(pcm_left) || $changed(pcm_right)) && reset_pin_n
    && $past(reset_pin_n) |-> pcm_valid || $past(pcm_valid)) else $error("pcm moved alone");
  AST_COLD: assert property (low_cnt >= 8'h82 |-> !codec_ready && !bit_clk)
    else $error("link alive in cold reset");
endmodule // aclc_codec_props

bind aclc_codec aclc_codec_props aclc_codec_props_i (.clock(clock), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .reset_pin_n(reset_pin_n), .sync(sync),
  .sdata_out(sdata_out), .bit_clk(bit_clk), .sdata_in(sdata_in), .codec_ready(codec_ready),
  .pcm_left(pcm_left), .pcm_right(pcm_right), .pcm_valid(pcm_valid));

// ===== tb/aclc_ctrl_model.sv
/*
  Behavioural link controller: makes sync from the bit clock, sends frames, captures replies.
  Assumes the bench sets frm before each load and the bit clock is slow against clock.
*/
`timescale 1ns/1ps
module aclc_ctrl_model (
  input  wire logic        clock,      // System clock
  input  wire logic        rstn,       // Reset, active low
  input  wire logic        bit_clk,    // From codec
  input  wire logic        sdata_in,   // From codec
  input  wire logic        wake,       // Hold sync high
  input  wire logic [95:0] frm,        // Tag and slots 1 to 4
  output logic             sync,       // To codec
  output logic             sdata_out,  // To codec
  output logic             done,       // Pulse: frame loaded
  output logic      [55:0] rx          // Last incoming tag, slots 1 and 2
);
  logic         bq;
  logic         sy;
  logic [7:0]   c;
  logic [255:0] sr;
  logic [255:0] ir;
  assign sync = wake | sy;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bq <= 1'b0;
      sy <= 1'b0;
      c <= 8'h00;
      sr <= '0;
      ir <= '0;
      rx <= '0;
      sdata_out <= 1'b0;
      done <= 1'b0;
    end else begin
      bq <= bit_clk;
      done <= 1'b0;
      if (bit_clk && !bq) begin
        sy <= c < 8'h10;
        sdata_out <= sr[255];
        sr <= {sr[254:0], 1'b0};
        c <= c + 8'h01;
      end
      if (!bit_clk && bq) begin
        ir <= {ir[254:0], sdata_in};
        if (c == 8'h01) begin
          sr <= {frm, 160'h0};
          rx <= ir[254:199];
          done <= 1'b1;
        end
      end
    end
  end
endmodule // aclc_ctrl_model

// ===== tb/tb_top.sv
/*
  Directed bench: link register traffic, playback, resets, APB status access.
  Assumes aclc_codec, aclc_ctrl_model and the bound checker.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clock, rstn, psel, penable, pwrite, pready, pslverr, reset_pin_n;
  logic        sync, sdata_out, bit_clk, sdata_in, codec_ready, pcm_valid, wake, done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [19:0] pcm_left, pcm_right;
  logic [95:0] frm;
  logic [55:0] rx;
  logic        rerr;
  int          n_fail, checks_done, cyc;

  aclc_codec aclc_codec_i (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n), .sync(sync), .sdata_out(sdata_out),
    .bit_clk(bit_clk), .sdata_in(sdata_in), .codec_ready(codec_ready),
    .pcm_left(pcm_left), .pcm_right(pcm_right), .pcm_valid(pcm_valid));
  aclc_ctrl_model aclc_ctrl_model_i (.clock(clock), .rstn(rstn), .bit_clk(bit_clk),
    .sdata_in(sdata_in), .wake(wake), .frm(frm), .sync(sync), .sdata_out(sdata_out),
    .done(done), .rx(rx));

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Frame sent from the next load; rx then holds the frame before it
  task automatic xfer(input logic [95:0] f);
    frm <= f;
    do @(posedge clock); while (done !== 1'b1);
  endtask
  task automatic wr(input logic [6:0] i, input logic [15:0] d);
    xfer({16'hE000, 1'b0, i, 12'h000, d, 4'h0, 40'h0});
  endtask
  task automatic rd(input logic [6:0] i, input logic [15:0] d);
    xfer({16'hC000, 1'b1, i, 12'h000, 60'h0});
    xfer(96'h0);
    xfer(96'h0);
    chk("rx_tag", 32'h3, 32'(rx[54:53]));
    chk("rx_idx", 32'(i), 32'(rx[38:32]));
    chk("rx_dat", 32'({d, 4'h0}), 32'(rx[19:0]));
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wait_ready;
    int k;
    k = 0;
    while (codec_ready !== 1'b1 && k < 6000) begin
      @(posedge clock);
      k++;
    end
    chk("ready", 32'h1, 32'(codec_ready));
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    reset_pin_n = 1'b1;
    wake = 1'b0;
    frm = 96'h0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    wait_ready();
    xfer(96'h0);
    xfer(96'h0);
    chk("rx_rdy", 32'h1, 32'(rx[55]));
    chk("rx_idle", 32'h0, 32'({rx[53], rx[19:0]}));
    for (int n = 0; n < 2; n++) begin
      wr(7'(2 * n + 2), n == 0 ? 16'hFFFF : 16'hA5C3);
      rd(7'(2 * n + 2), n == 0 ? 16'hFFFF : 16'hA5C3);
    end
    wr(7'h03, 16'h5555);
    rd(7'h03, 16'h0000);
    xfer({16'h6000, 20'h04000, 20'h11110, 40'h0});
    xfer({16'hE001, 20'h04000, 20'h22220, 40'h0});
    rd(7'h04, 16'hA5C3);
    xfer({16'h9800, 40'h0, 20'h12345, 20'hABCDE});
    xfer({16'h1800, 40'h0, 20'h11111, 20'h22222});
    xfer(96'h0);
    chk("pcm_l", 32'h12345, 32'(pcm_left));
    chk("pcm_r", 32'hABCDE, 32'(pcm_right));
    apb(1'b0, aclc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h1, rdat);
    apb(1'b0, aclc_pkg::OFF_PCM_L, 32'h0);
    chk("apb_pcm", 32'h12345, rdat);
    apb(1'b0, aclc_pkg::OFF_CMD, 32'h0);
    chk("apb_cmd", 32'h8040_0000, rdat);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, 32'(rerr));
    chk("unmap", 32'h0, rdat);
    apb(1'b1, aclc_pkg::OFF_CTRL, 32'h0);
    repeat (4) @(posedge clock);
    chk("rdy_off", 32'h0, 32'(codec_ready));
    apb(1'b1, aclc_pkg::OFF_CTRL, 32'h1);
    wait_ready();
    wr(aclc_pkg::IDX_RESET, 16'h0000);
    rd(7'h02, 16'h0000);
    wr(7'h02, 16'hBEEF);
    wr(aclc_pkg::IDX_PWR, 16'h1000);
    frm <= 96'h0;
    repeat (2500) @(posedge clock);
    chk("halt", 32'h0, 32'({bit_clk, codec_ready}));
    wake <= 1'b1;
    repeat (120) @(posedge clock);
    wake <= 1'b0;
    wait_ready();
    rd(7'h02, 16'hBEEF);
    reset_pin_n <= 1'b0;
    repeat (40) @(posedge clock);
    reset_pin_n <= 1'b1;
    repeat (20) @(posedge clock);
    chk("short", 32'h1, 32'(codec_ready));
    reset_pin_n <= 1'b0;
    repeat (150) @(posedge clock);
    chk("cold", 32'h0, 32'({bit_clk, codec_ready}));
    reset_pin_n <= 1'b1;
    wait_ready();
    rd(7'h02, 16'h0000);
    complete_run();
  end
endmodule // tb_top
